// ==== lf_sweep_pkg.sv ====
// constants shared by the low-frequency sweep sequencer
`default_nettype none
package lf_sweep_pkg;
    // register word addresses
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_START = 4'h1;
    localparam logic [3:0] ADR_STOP = 4'h2;
    localparam logic [3:0] ADR_LIN_STEP = 4'h3;
    localparam logic [3:0] ADR_LOG_STEP = 4'h4;
    localparam logic [3:0] ADR_DWELL = 4'h5;
    localparam logic [3:0] ADR_POINTS = 4'h6;
    localparam logic [3:0] ADR_MANUAL = 4'h7;
    localparam logic [3:0] ADR_EXEC = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'h9;
    localparam logic [3:0] ADR_CUR_FREQ = 4'ha;
    localparam logic [3:0] ADR_FIXED = 4'hb;
    // control register fields
    localparam int CTL_SWEEP = 0;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_MODE_HI = 2;
    localparam int CTL_TRI = 3;
    localparam int CTL_LOG = 4;
    localparam int CTL_RETRACE = 5;
    localparam int CTL_W = 6;
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_STEP = 2'h2;
    // values after reset; frequencies in 0.1 Hz, log factor in 0.01 %, dwell in 100 us
    localparam logic [CTL_W-1:0] RST_CTRL = 6'h00;
    localparam logic [31:0] RST_FREQ = 32'h0000_2710;
    localparam logic [31:0] RST_LIN_STEP = 32'h0000_2710;
    localparam logic [13:0] RST_LOG_STEP = 14'h0064;
    localparam logic [13:0] LOG_STEP_MIN = 14'h0001;
    localparam logic [13:0] LOG_STEP_MAX = 14'h2710;
    localparam logic [31:0] LOG_SCALE = 32'h0000_2710;
    localparam logic [31:0] FREQ_MIN = 32'h0000_0001;
    localparam logic [31:0] FREQ_MAX = 32'h0098_9680;
    localparam logic [19:0] RST_DWELL = 20'h00064;
    localparam logic [19:0] DWELL_MIN = 20'h0000a;
    localparam logic [19:0] DWELL_MAX = 20'hf4240;
    localparam logic [15:0] RST_POINTS = 16'h0032;
    localparam logic [15:0] POINTS_MIN = 16'h0002;
    // timing: one dwell unit of 100 us at a 25 ns clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int DWELL_UNIT_NS = 100000;
    localparam int DWELL_TICKS = DWELL_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [11:0] TICK_LAST = 12'(DWELL_TICKS - 1);
    typedef enum logic {ST_IDLE, ST_RUN} sweep_state_e;
endpackage
`default_nettype wire

// ==== lf_sweep_seq.sv ====
// frequency sweep sequencer for the low-frequency generator
`default_nettype none
// Behaviour
// - an execute write starts a sweep at once, kind set by cycle mode
// - auto mode: one trigger runs a full sweep start to stop; auto is default
// - auto mode: each step is held for the dwell time, then advances
// - manual mode: triggers ignored; writing the manual frequency makes each step
// - step mode: each trigger advances exactly one step
// - advance adds linear width, or applies the log factor, per spacing
// - point count settable, never below 2, resets to 50
// - retrace returns output to start while waiting; off after reset
// - running flag reads 1 while an auto sweep runs or, in sweep mode, any mode but auto is set, else 0
// - shape sawtooth or triangle, sawtooth after reset
// - spacing linear or logarithmic, linear after reset
// - log factor 0.01 to 100 percent in 0.01 steps, resets to 1
// - linear width from 0.1 in 0.1 steps, resets to 1000
// - dwell 0.001 to 100 s in 100 us steps, resets to 0.01 s
// - start and stop 0.1 Hz to 1 MHz, reset 1 kHz, used in sweep mode
// - frequency mode fixed or sweep, fixed after reset; sequencing only in sweep
module lf_sweep_seq (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic [31:0] FREQ_OUT,
    output logic RUNNING
);
    logic [lf_sweep_pkg::CTL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [31:0] start_ff, nxt_start, stop_ff, nxt_stop, lin_ff, nxt_lin, fixed_ff, nxt_fixed;
    logic [13:0] log_ff, nxt_log;
    logic [19:0] dwell_ff, nxt_dwell;
    logic [15:0] points_ff, nxt_points;
    lf_sweep_pkg::sweep_state_e state_ff, nxt_state;
    logic [31:0] cur_ff, nxt_cur;
    logic [15:0] cnt_ff, nxt_cnt;
    logic dir_ff, nxt_dir;
    logic [11:0] tick_ff, nxt_tick;
    logic [19:0] left_ff, nxt_left;
    logic [31:0] rdata_ff, nxt_rdata, fout_ff, nxt_fout;
    logic run_ff, nxt_run;
    logic sweep_on, is_tri, is_log, retrace, exec, man_wr;
    logic [1:0] mode;
    logic at_top, at_bot, end_leg, tick_wrap;
    logic [31:0] up_f, dn_f, adv_f;
    logic [15:0] adv_cnt;
    logic adv_dir;

    // clamp a written value into its legal range
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        if (v < lo)
            return lo;
        else if (v > hi)
            return hi;
        return v;
    endfunction

    // control field decode
    assign sweep_on = ctrl_ff[lf_sweep_pkg::CTL_SWEEP];
    assign mode = ctrl_ff[lf_sweep_pkg::CTL_MODE_HI:lf_sweep_pkg::CTL_MODE_LO];
    assign is_tri = ctrl_ff[lf_sweep_pkg::CTL_TRI];
    assign is_log = ctrl_ff[lf_sweep_pkg::CTL_LOG];
    assign retrace = ctrl_ff[lf_sweep_pkg::CTL_RETRACE];
    assign exec = WR && (ADDR == lf_sweep_pkg::ADR_EXEC);
    assign man_wr = WR && (ADDR == lf_sweep_pkg::ADR_MANUAL);

    // configuration writes; out-of-range values are clamped rather than refused
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_start = start_ff;
        nxt_stop = stop_ff;
        nxt_lin = lin_ff;
        nxt_log = log_ff;
        nxt_dwell = dwell_ff;
        nxt_points = points_ff;
        nxt_fixed = fixed_ff;
        if (WR)
        begin
            if (ADDR == lf_sweep_pkg::ADR_CTRL)
                nxt_ctrl = WDATA[lf_sweep_pkg::CTL_W-1:0];
            else if (ADDR == lf_sweep_pkg::ADR_START)
                nxt_start = clamp(WDATA, lf_sweep_pkg::FREQ_MIN, lf_sweep_pkg::FREQ_MAX);
            else if (ADDR == lf_sweep_pkg::ADR_STOP)
                nxt_stop = clamp(WDATA, lf_sweep_pkg::FREQ_MIN, lf_sweep_pkg::FREQ_MAX);
            else if (ADDR == lf_sweep_pkg::ADR_LIN_STEP)
                nxt_lin = clamp(WDATA, lf_sweep_pkg::FREQ_MIN, lf_sweep_pkg::FREQ_MAX);
            else if (ADDR == lf_sweep_pkg::ADR_LOG_STEP)
                nxt_log = 14'(clamp(WDATA, 32'(lf_sweep_pkg::LOG_STEP_MIN),
                                     32'(lf_sweep_pkg::LOG_STEP_MAX)));
            else if (ADDR == lf_sweep_pkg::ADR_DWELL)
                nxt_dwell = 20'(clamp(WDATA, 32'(lf_sweep_pkg::DWELL_MIN),
                                       32'(lf_sweep_pkg::DWELL_MAX)));
            else if (ADDR == lf_sweep_pkg::ADR_POINTS)
                nxt_points = 16'(clamp(WDATA, 32'(lf_sweep_pkg::POINTS_MIN), 32'h0000_ffff));
            else if (ADDR == lf_sweep_pkg::ADR_FIXED)
                nxt_fixed = clamp(WDATA, lf_sweep_pkg::FREQ_MIN, lf_sweep_pkg::FREQ_MAX);
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl_ff <= lf_sweep_pkg::RST_CTRL;
            start_ff <= lf_sweep_pkg::RST_FREQ;
            stop_ff <= lf_sweep_pkg::RST_FREQ;
            lin_ff <= lf_sweep_pkg::RST_LIN_STEP;
            log_ff <= lf_sweep_pkg::RST_LOG_STEP;
            dwell_ff <= lf_sweep_pkg::RST_DWELL;
            points_ff <= lf_sweep_pkg::RST_POINTS;
            fixed_ff <= lf_sweep_pkg::RST_FREQ;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            start_ff <= nxt_start;
            stop_ff <= nxt_stop;
            lin_ff <= nxt_lin;
            log_ff <= nxt_log;
            dwell_ff <= nxt_dwell;
            points_ff <= nxt_points;
            fixed_ff <= nxt_fixed;
        end
    end

    // next frequency up or down; the divider is costly and is evaluated every cycle, though its result is used only per step
    always_comb
    begin
        logic [47:0] inc;
        logic [47:0] dec;
        inc = (48'(cur_ff) * 48'(log_ff)) / 48'(lf_sweep_pkg::LOG_SCALE);
        dec = (48'(cur_ff) * 48'(log_ff)) / (48'(lf_sweep_pkg::LOG_SCALE) + 48'(log_ff));
        if (inc == 48'h0)
            inc = 48'h1;
        if (dec == 48'h0)
            dec = 48'h1;
        if (!is_log)
        begin
            inc = 48'(lin_ff);
            dec = 48'(lin_ff);
        end
        up_f = (48'(cur_ff) + inc >= 48'(stop_ff)) ? stop_ff : 32'(48'(cur_ff) + inc);
        dn_f = (48'(cur_ff) <= 48'(start_ff) + dec) ? start_ff : 32'(48'(cur_ff) - dec);
    end

    // leg ends at the stop frequency or after the point count is used up
    assign at_top = (cur_ff >= stop_ff) || (32'(cnt_ff) + 32'h1 >= 32'(points_ff));
    assign at_bot = (cur_ff <= start_ff) || (cnt_ff == 16'h0);
    assign end_leg = is_tri ? (dir_ff && at_bot) : at_top;
    assign tick_wrap = (tick_ff == lf_sweep_pkg::TICK_LAST);

    // one advance, turning or wrapping at the ends of the legs
    always_comb
    begin
        adv_f = up_f;
        adv_cnt = cnt_ff + 16'h1;
        adv_dir = dir_ff;
        if (!dir_ff && at_top)
        begin
            if (is_tri)
            begin
                adv_f = dn_f;
                adv_cnt = cnt_ff - 16'h1;
                adv_dir = 1'b1;
            end
            else
            begin
                adv_f = start_ff;
                adv_cnt = 16'h0;
            end
        end
        else if (dir_ff)
        begin
            adv_f = at_bot ? up_f : dn_f;
            adv_cnt = at_bot ? 16'h1 : cnt_ff - 16'h1;
            adv_dir = !at_bot;
        end
    end

    // sequencing, output mux and read port
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        nxt_tick = tick_ff;
        nxt_left = left_ff;
        case (state_ff)
            lf_sweep_pkg::ST_IDLE:
            begin
                // execute starts an auto sweep from the start frequency
                if (sweep_on && exec && mode == lf_sweep_pkg::MODE_AUTO)
                begin
                    nxt_state = lf_sweep_pkg::ST_RUN;
                    nxt_cur = start_ff;
                    nxt_cnt = 16'h0;
                    nxt_dir = 1'b0;
                    nxt_tick = 12'h0;
                    nxt_left = dwell_ff;
                end
                // step mode advances once per trigger
                else if (sweep_on && exec && mode == lf_sweep_pkg::MODE_STEP)
                begin
                    nxt_cur = adv_f;
                    nxt_cnt = adv_cnt;
                    nxt_dir = adv_dir;
                end
                // manual mode takes frequency from software, triggers ignored
                else if (sweep_on && man_wr && mode == lf_sweep_pkg::MODE_MANUAL)
                    nxt_cur = clamp(WDATA, lf_sweep_pkg::FREQ_MIN, lf_sweep_pkg::FREQ_MAX);
            end
            lf_sweep_pkg::ST_RUN:
            begin
                if (!sweep_on || mode != lf_sweep_pkg::MODE_AUTO)
                    nxt_state = lf_sweep_pkg::ST_IDLE;
                // a new execute restarts the sweep at once
                else if (exec)
                begin
                    nxt_cur = start_ff;
                    nxt_cnt = 16'h0;
                    nxt_dir = 1'b0;
                    nxt_tick = 12'h0;
                    nxt_left = dwell_ff;
                end
                // hold each step for the dwell time
                else if (!tick_wrap)
                    nxt_tick = tick_ff + 12'h1;
                else
                begin
                    nxt_tick = 12'h0;
                    nxt_left = left_ff - 20'h1;
                    if (left_ff <= 20'h1)
                    begin
                        nxt_left = dwell_ff;
                        // final dwell over: stop, retrace to start if asked
                        if (end_leg)
                        begin
                            nxt_state = lf_sweep_pkg::ST_IDLE;
                            nxt_cur = retrace ? start_ff : cur_ff;
                            nxt_cnt = 16'h0;
                            nxt_dir = 1'b0;
                        end
                        else
                        begin
                            nxt_cur = adv_f;
                            nxt_cnt = adv_cnt;
                            nxt_dir = adv_dir;
                        end
                    end
                end
            end
            default:
                nxt_state = lf_sweep_pkg::ST_IDLE;
        endcase
        // running while an auto sweep runs or a stepping mode is armed
        nxt_run = sweep_on && ((nxt_state == lf_sweep_pkg::ST_RUN)
                               || (mode != lf_sweep_pkg::MODE_AUTO));
        // fixed mode drives the fixed frequency, sweep mode the sequencer
        nxt_fout = sweep_on ? nxt_cur : fixed_ff;
        nxt_rdata = 32'h0;
        if (RD)
        begin
            if (ADDR == lf_sweep_pkg::ADR_CTRL)
                nxt_rdata = 32'(ctrl_ff);
            else if (ADDR == lf_sweep_pkg::ADR_START)
                nxt_rdata = start_ff;
            else if (ADDR == lf_sweep_pkg::ADR_STOP)
                nxt_rdata = stop_ff;
            else if (ADDR == lf_sweep_pkg::ADR_LIN_STEP)
                nxt_rdata = lin_ff;
            else if (ADDR == lf_sweep_pkg::ADR_LOG_STEP)
                nxt_rdata = 32'(log_ff);
            else if (ADDR == lf_sweep_pkg::ADR_DWELL)
                nxt_rdata = 32'(dwell_ff);
            else if (ADDR == lf_sweep_pkg::ADR_POINTS)
                nxt_rdata = 32'(points_ff);
            else if (ADDR == lf_sweep_pkg::ADR_STATUS)
                nxt_rdata = {31'h0, run_ff};
            else if (ADDR == lf_sweep_pkg::ADR_CUR_FREQ || ADDR == lf_sweep_pkg::ADR_MANUAL)
                nxt_rdata = cur_ff;
            else if (ADDR == lf_sweep_pkg::ADR_FIXED)
                nxt_rdata = fixed_ff;
        end
    end

    // sequencer state registers
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_ff <= lf_sweep_pkg::ST_IDLE;
            cur_ff <= lf_sweep_pkg::RST_FREQ;
            cnt_ff <= 16'h0;
            dir_ff <= 1'b0;
            tick_ff <= 12'h0;
            left_ff <= lf_sweep_pkg::RST_DWELL;
            run_ff <= 1'b0;
            fout_ff <= lf_sweep_pkg::RST_FREQ;
            rdata_ff <= 32'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
            tick_ff <= nxt_tick;
            left_ff <= nxt_left;
            run_ff <= nxt_run;
            fout_ff <= nxt_fout;
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;
    assign FREQ_OUT = fout_ff;
    assign RUNNING = run_ff;

    a_exec_starts: assert property (@(posedge CLK) disable iff (!RST_B)
        sweep_on && exec && mode == lf_sweep_pkg::MODE_AUTO
        |=> state_ff == lf_sweep_pkg::ST_RUN && cur_ff == $past(start_ff))
        else $error("execute did not start auto sweep");
    a_dwell_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        state_ff == lf_sweep_pkg::ST_RUN && !exec && !tick_wrap |=> $stable(cur_ff))
        else $error("frequency changed inside dwell");
    a_manual_trig: assert property (@(posedge CLK) disable iff (!RST_B)
        state_ff == lf_sweep_pkg::ST_IDLE && sweep_on && exec && mode == lf_sweep_pkg::MODE_MANUAL
        |=> $stable(cur_ff))
        else $error("manual mode reacted to trigger");
    a_step_once: assert property (@(posedge CLK) disable iff (!RST_B)
        sweep_on && exec && mode == lf_sweep_pkg::MODE_STEP && state_ff == lf_sweep_pkg::ST_IDLE
        ##1 !exec && !man_wr |=> $stable(cur_ff))
        else $error("step mode advanced more than once");
    a_points_min: assert property (@(posedge CLK) disable iff (!RST_B)
        points_ff >= lf_sweep_pkg::POINTS_MIN)
        else $error("point count below two");
    a_retrace_home: assert property (@(posedge CLK) disable iff (!RST_B)
        state_ff == lf_sweep_pkg::ST_RUN && nxt_state == lf_sweep_pkg::ST_IDLE && retrace
        && sweep_on && mode == lf_sweep_pkg::MODE_AUTO |=> cur_ff == $past(start_ff))
        else $error("retrace did not return to start");
    a_running_flag: assert property (@(posedge CLK) disable iff (!RST_B)
        $past(state_ff) == lf_sweep_pkg::ST_RUN && state_ff == lf_sweep_pkg::ST_RUN
        |-> RUNNING)
        else $error("running flag low during sweep");
    a_fixed_out: assert property (@(posedge CLK) disable iff (!RST_B)
        !sweep_on |=> FREQ_OUT == $past(fixed_ff))
        else $error("fixed mode output wrong");
    a_read_lat: assert property (@(posedge CLK) disable iff (!RST_B)
        RD && ADDR == lf_sweep_pkg::ADR_STATUS |=> RDATA == {31'h0, $past(run_ff)})
        else $error("status read wrong");
endmodule
`default_nettype wire

// ==== test_lf_sweep_seq.sv ====
// self-checking testbench for the low-frequency sweep sequencer
`default_nettype none
module test_lf_sweep_seq;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic [31:0] FREQ_OUT;
    logic RUNNING;
    int failures = 0;
    int n_compared = 0;
    int dwell_cyc;
    logic [31:0] tri_seq [6] = '{32'h44c, 32'h4b0, 32'h514, 32'h4b0, 32'h44c, 32'h3e8};

    lf_sweep_seq lf_sweep_seq_inst (
        .CLK(CLK),
        .RST_B(RST_B),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR(WR),
        .RD(RD),
        .RDATA(RDATA),
        .FREQ_OUT(FREQ_OUT),
        .RUNNING(RUNNING)
    );

    // 40 MHz clock
    always #12.5 CLK = ~CLK;

    // compare one value; four-state so an unknown never matches
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one-cycle write strobe, returns at the edge that takes it
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check(what, exp, RDATA);
    endtask

    // look at the outputs once the last edge has settled
    task automatic out_chk(input logic [31:0] f, input logic r);
        #1;
        check("FREQ_OUT", f, FREQ_OUT);
        check("RUNNING", {31'h0, r}, {31'h0, RUNNING});
    endtask

    // trigger once and expect the given frequency
    task automatic exec_chk(input logic [31:0] f);
        reg_wr(lf_sweep_pkg::ADR_EXEC, 32'h0);
        #1;
        check("FREQ_OUT step", f, FREQ_OUT);
    endtask

    task automatic stop_test();
        $display("Compared %0d values, %0d mismatches", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // cut a hang short; the tests need about 80000 cycles, this allows 92000
    initial
    begin
        #2300000;
        failures++;
        stop_test();
    end

    initial
    begin
        dwell_cyc = 10 * lf_sweep_pkg::DWELL_TICKS;
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        out_chk(32'h2710, 1'b0);
        rd_chk("CTRL", lf_sweep_pkg::ADR_CTRL, 32'h0);
        rd_chk("START", lf_sweep_pkg::ADR_START, 32'h2710);
        rd_chk("STOP", lf_sweep_pkg::ADR_STOP, 32'h2710);
        rd_chk("LIN", lf_sweep_pkg::ADR_LIN_STEP, 32'h2710);
        rd_chk("LOG", lf_sweep_pkg::ADR_LOG_STEP, 32'h64);
        rd_chk("DWELL", lf_sweep_pkg::ADR_DWELL, 32'h64);
        rd_chk("POINTS", lf_sweep_pkg::ADR_POINTS, 32'h32);
        rd_chk("STATUS", lf_sweep_pkg::ADR_STATUS, 32'h0);
        // unmapped place and read-only status ignore writes
        reg_wr(4'hc, 32'h5);
        rd_chk("unmapped", 4'hc, 32'h0);
        reg_wr(lf_sweep_pkg::ADR_STATUS, 32'h1);
        rd_chk("STATUS ro", lf_sweep_pkg::ADR_STATUS, 32'h0);
        reg_wr(lf_sweep_pkg::ADR_POINTS, 32'h1);
        rd_chk("POINTS min", lf_sweep_pkg::ADR_POINTS, 32'h2);
        reg_wr(lf_sweep_pkg::ADR_LOG_STEP, 32'h0);
        rd_chk("LOG min", lf_sweep_pkg::ADR_LOG_STEP, 32'h1);
        reg_wr(lf_sweep_pkg::ADR_LOG_STEP, 32'h4e20);
        rd_chk("LOG max", lf_sweep_pkg::ADR_LOG_STEP, 32'h2710);
        reg_wr(lf_sweep_pkg::ADR_DWELL, 32'h0);
        rd_chk("DWELL min", lf_sweep_pkg::ADR_DWELL, 32'ha);
        reg_wr(lf_sweep_pkg::ADR_LIN_STEP, 32'h0);
        rd_chk("LIN min", lf_sweep_pkg::ADR_LIN_STEP, 32'h1);
        reg_wr(lf_sweep_pkg::ADR_START, 32'h0);
        rd_chk("START min", lf_sweep_pkg::ADR_START, 32'h1);
        reg_wr(lf_sweep_pkg::ADR_START, 32'h00ff_ffff);
        rd_chk("START max", lf_sweep_pkg::ADR_START, 32'h0098_9680);
        // fixed mode follows the fixed value and ignores a trigger
        reg_wr(lf_sweep_pkg::ADR_FIXED, 32'h1388);
        reg_wr(lf_sweep_pkg::ADR_EXEC, 32'h0);
        out_chk(32'h1388, 1'b0);
        // manual mode: written value is the step, trigger ignored
        reg_wr(lf_sweep_pkg::ADR_POINTS, 32'h32);
        reg_wr(lf_sweep_pkg::ADR_START, 32'h3e8);
        reg_wr(lf_sweep_pkg::ADR_STOP, 32'h514);
        reg_wr(lf_sweep_pkg::ADR_LIN_STEP, 32'h64);
        reg_wr(lf_sweep_pkg::ADR_CTRL, 32'h03);
        reg_wr(lf_sweep_pkg::ADR_MANUAL, 32'h3e8);
        exec_chk(32'h3e8);
        // step mode, linear sawtooth wraps to start
        reg_wr(lf_sweep_pkg::ADR_CTRL, 32'h05);
        rd_chk("STATUS step", lf_sweep_pkg::ADR_STATUS, 32'h1);
        exec_chk(32'h44c);
        exec_chk(32'h4b0);
        exec_chk(32'h514);
        exec_chk(32'h3e8);
        repeat (10) @(posedge CLK);
        out_chk(32'h3e8, 1'b1);
        rd_chk("CUR_FREQ", lf_sweep_pkg::ADR_CUR_FREQ, 32'h3e8);
        // triangle turns at stop and comes back down
        reg_wr(lf_sweep_pkg::ADR_CTRL, 32'h0d);
        foreach (tri_seq[i])
            exec_chk(tri_seq[i]);
        // log steps of ten percent, clipped at stop
        reg_wr(lf_sweep_pkg::ADR_LOG_STEP, 32'h3e8);
        reg_wr(lf_sweep_pkg::ADR_CTRL, 32'h13);
        reg_wr(lf_sweep_pkg::ADR_MANUAL, 32'h3e8);
        reg_wr(lf_sweep_pkg::ADR_CTRL, 32'h15);
        exec_chk(32'h44c);
        exec_chk(32'h4ba);
        exec_chk(32'h514);
        exec_chk(32'h3e8);
        // auto sawtooth single sweep with retrace, two points one dwell each
        reg_wr(lf_sweep_pkg::ADR_LIN_STEP, 32'h12c);
        reg_wr(lf_sweep_pkg::ADR_POINTS, 32'h2);
        reg_wr(lf_sweep_pkg::ADR_DWELL, 32'ha);
        reg_wr(lf_sweep_pkg::ADR_CTRL, 32'h21);
        // running is registered, so it follows the new mode one edge later
        @(posedge CLK);
        #1;
        check("RUNNING idle", 32'h0, {31'h0, RUNNING});
        reg_wr(lf_sweep_pkg::ADR_EXEC, 32'h0);
        out_chk(32'h3e8, 1'b1);
        repeat (dwell_cyc - 10) @(posedge CLK);
        out_chk(32'h3e8, 1'b1);
        repeat (20) @(posedge CLK);
        out_chk(32'h514, 1'b1);
        repeat (dwell_cyc - 20) @(posedge CLK);
        out_chk(32'h514, 1'b1);
        repeat (20) @(posedge CLK);
        // retrace on: output goes back to start while waiting for a trigger
        out_chk(32'h3e8, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
